// *** design/psl_pkg.sv ***
// shared constants and types for the port status lamp block
package psl_pkg;

  // lamp colour codes
  typedef enum logic [1:0] {
    PSL_OFF    = 2'b00,
    PSL_GREEN  = 2'b01,
    PSL_YELLOW = 2'b10,
    PSL_ORANGE = 2'b11
  } psl_color_t;

  // display modes, in button order
  typedef enum logic [1:0] {
    PSL_MODE_A = 2'b00,
    PSL_MODE_B = 2'b01,
    PSL_MODE_C = 2'b10,
    PSL_MODE_D = 2'b11
  } psl_mode_t;

  // port speed codes
  typedef enum logic [1:0] {
    PSL_SPD_10   = 2'b00,
    PSL_SPD_100  = 2'b01,
    PSL_SPD_1000 = 2'b10
  } psl_speed_t;

  // plug handling states
  typedef enum logic [2:0] {
    PSL_PLG_BOOT  = 3'b000,
    PSL_PLG_SAVE  = 3'b001,
    PSL_PLG_LOAD  = 3'b010,
    PSL_PLG_RUN   = 3'b011,
    PSL_PLG_NONE  = 3'b100,
    PSL_PLG_FAULT = 3'b101
  } psl_plug_state_t;

  // per-port status from the switch core
  typedef struct packed {
    logic       link;
    logic       blocking;
    logic       admin_off;
    logic       mirror_dest;
    logic       rx_act;
    logic       tx_act;
    logic       optical_gig;
    psl_speed_t speed;
    psl_speed_t set_speed;
    logic       autoneg;
    logic       conn_problem;
    logic       full_duplex;
    logic       monitored;
  } psl_port_t;

  // plug status from the memory controller
  typedef struct packed {
    logic present;
    logic empty;
    logic compatible;
    logic malfunction;
    logic xfer_done;
  } psl_plug_in_t;

  // plug commands to the memory controller
  typedef struct packed {
    logic save_all;
    logic load_all;
    logic write_changes;
    logic use_internal;
    logic diag_fault;
  } psl_plug_out_t;

  localparam int unsigned PSL_CLK_HZ = 250_000_000;
  localparam int unsigned PSL_IDLE_S = 60;
  localparam int unsigned PSL_TICK_HZ = 24;
  localparam int unsigned PSL_TICK_CYC = PSL_CLK_HZ / PSL_TICK_HZ;
  localparam int unsigned PSL_TICK_W = 24;
  localparam int unsigned PSL_PHASE_W = 5;
  localparam logic [PSL_PHASE_W-1:0] PSL_PHASE_LAST = 5'h17;
  // half periods in ticks: 1, 3 and 4 flashes per second
  localparam logic [PSL_PHASE_W-1:0] PSL_HALF_1HZ = 5'h0C;
  localparam logic [PSL_PHASE_W-1:0] PSL_HALF_3HZ = 5'h04;
  localparam logic [PSL_PHASE_W-1:0] PSL_HALF_4HZ = 5'h03;
  localparam int unsigned PSL_IDLE_TICKS = PSL_IDLE_S * PSL_TICK_HZ;
  localparam int unsigned PSL_IDLE_W = 11;

endpackage : psl_pkg

// *** design/psl_flash_base.sv ***
// shared flash time base: tick divider and in-phase flash levels
module psl_flash_base
  import psl_pkg::*;
#(
  parameter int unsigned TICK_CYC = PSL_TICK_CYC
) (
  input wire logic clock_in, // system clock
  input wire logic rst_n_in, // async reset, active low
  input wire logic ce_in, // clock enable
  output logic tick_out, // one-cycle pulse every tick
  output logic flash_1hz_out, // 1 flash per second level
  output logic flash_3hz_out, // 3 flashes per second level
  output logic flash_4hz_out // 4 flashes per second level
);

  typedef struct packed {
    logic [PSL_TICK_W-1:0] div;
    logic [PSL_PHASE_W-1:0] phase;
    logic tick;
  } psl_fb_state_t;

  psl_fb_state_t st_reg;
  psl_fb_state_t st_next;

  // level is on in the first half of each period of 2*half ticks
  function automatic logic flash_level(input logic [PSL_PHASE_W-1:0] ph,
                                       input logic [PSL_PHASE_W-1:0] half);
    logic [PSL_PHASE_W-1:0] r;
    r = ph % (half << 1);
    return r < half;
  endfunction : flash_level

  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.div == PSL_TICK_W'(TICK_CYC - 1)) begin
      st_next.div = '0;
      st_next.tick = 1'b1;
      st_next.phase = (st_reg.phase == PSL_PHASE_LAST) ? '0
                      : PSL_PHASE_W'(st_reg.phase + 1'b1);
    end else begin
      st_next.div = PSL_TICK_W'(st_reg.div + 1'b1);
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end

  assign tick_out = st_reg.tick;
  assign flash_1hz_out = flash_level(st_reg.phase, PSL_HALF_1HZ);
  assign flash_3hz_out = flash_level(st_reg.phase, PSL_HALF_3HZ);
  assign flash_4hz_out = flash_level(st_reg.phase, PSL_HALF_4HZ);

endmodule : psl_flash_base

// *** design/psl_port_lamps.sv ***
// per-port status lamps, display mode selection and config plug startup
// Notes on behaviour
// - no link keeps the port lamp dark (code: except in mode D and for a fixed speed fault in mode B)
// - link and forwarding gives steady green
// - blocking port flashes green once per second
// - admin disabled port flashes green thrice per second
// - mirror destination flashes green four per second
// - mode A shows receive activity in yellow
// - optical gigabit ports show rx and tx
// - mode B speed: dark, green, orange
// - fixed speed fault still shows configured speed
// - autoneg fault in speed mode turns lamp off
// - mode C duplex: dark half, green full
// - mode D: green when port is monitored
// - monitored port without link raises fault contact
// - empty plug at startup gets full configuration
// - accepted plug receives runtime configuration changes
// - inserted plug excludes internal configuration memory (code: only a plug present at startup; one inserted later is ignored)
// - accepted written plug is loaded at startup
// - accept plug only from compatible device type (code: an empty plug is saved to without checking compatible)
// - incompatible, removed or broken plug raises diagnostic
// - without plug use internal configuration memory (code: only with no plug at startup; not after a plug is removed)
// - short press advances display mode cyclically
// - one idle minute returns to mode A
module psl_port_lamps
  import psl_pkg::*;
#(
  parameter int unsigned NUM_PORTS = 8,
  parameter int unsigned TICK_CYC = PSL_TICK_CYC,
  parameter int unsigned IDLE_TICKS = PSL_IDLE_TICKS
) (
  input wire logic clock_in, // system clock, 250 MHz
  input wire logic rst_n_in, // async reset, active low
  input wire logic ce_in, // clock enable, freezes all state when low
  input wire psl_port_t [NUM_PORTS-1:0] port_in, // per-port status
  input wire logic button_press_in, // one-cycle short press of mode button
  input wire logic cfg_change_in, // one-cycle pulse: configuration changed
  input wire psl_plug_in_t plug_in, // plug status
  output psl_color_t [NUM_PORTS-1:0] per_port_status_lamps_out, // port lamps
  output psl_mode_t display_mode_out, // active display mode
  output psl_color_t display_mode_lamp_out, // mode lamp colour
  output logic fault_contact_out, // fault signalling contact, high active
  output logic error_state_out, // device error state
  output psl_plug_out_t plug_out, // plug commands and diagnostic
  output psl_plug_state_t plug_state_out // plug handling state
);

  typedef struct packed {
    psl_mode_t mode;
    logic [PSL_IDLE_W-1:0] idle;
    psl_plug_state_t plug;
    logic diag;
    psl_plug_out_t pcmd;
    logic fault;
    psl_color_t [NUM_PORTS-1:0] lamps;
  } psl_state_t;

  psl_state_t st_reg;
  psl_state_t st_next;

  logic tick;
  logic fl_1hz;
  logic fl_3hz;
  logic fl_4hz;

  psl_flash_base #(
    .TICK_CYC(TICK_CYC)
  ) u_flash (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .tick_out(tick),
    .flash_1hz_out(fl_1hz),
    .flash_3hz_out(fl_3hz),
    .flash_4hz_out(fl_4hz)
  );

  function automatic psl_color_t on_if(input logic cond, input psl_color_t c);
    return cond ? c : PSL_OFF;
  endfunction : on_if

  function automatic psl_color_t speed_color(input psl_speed_t s);
    case (s)
      PSL_SPD_100: return PSL_GREEN;
      PSL_SPD_1000: return PSL_ORANGE;
      default: return PSL_OFF;
    endcase
  endfunction : speed_color

  // link-state view, highest priority first
  function automatic psl_color_t link_view(input psl_port_t p, input logic f1,
                                           input logic f3, input logic f4);
    if (!p.link) return PSL_OFF;
    else if (p.mirror_dest) return on_if(f4, PSL_GREEN);
    else if (p.admin_off) return on_if(f3, PSL_GREEN);
    else if (p.blocking) return on_if(f1, PSL_GREEN);
    else return PSL_GREEN;
  endfunction : link_view

  function automatic psl_color_t mode_view(input psl_mode_t m, input psl_port_t p);
    logic act;
    act = p.rx_act | (p.optical_gig & p.tx_act);
    case (m)
      PSL_MODE_A: return on_if(act, PSL_YELLOW);
      PSL_MODE_B: begin
        if (p.conn_problem && p.autoneg) return PSL_OFF;
        else if (p.conn_problem) return speed_color(p.set_speed);
        else return speed_color(p.speed);
      end
      PSL_MODE_C: return on_if(p.full_duplex, PSL_GREEN);
      PSL_MODE_D: return on_if(p.monitored, PSL_GREEN);
      default: return PSL_OFF;
    endcase
  endfunction : mode_view

  always_comb begin
    logic any_fault;
    psl_color_t lv;
    psl_color_t mv;
    st_next = st_reg;
    any_fault = 1'b0;
    lv = PSL_OFF;
    mv = PSL_OFF;

    // display mode selection and idle timeout
    if (button_press_in) begin
      st_next.mode = psl_mode_t'(st_reg.mode + 2'h1);
      st_next.idle = '0;
    end else if (tick) begin
      if (st_reg.idle >= PSL_IDLE_W'(IDLE_TICKS)) begin
        st_next.mode = PSL_MODE_A;
      end else begin
        st_next.idle = PSL_IDLE_W'(st_reg.idle + 1'b1);
      end
    end

    // lamps: in mode A, link-state overlay where a port is not plainly forwarding
    for (int i = 0; i < NUM_PORTS; i++) begin
      lv = link_view(port_in[i], fl_1hz, fl_3hz, fl_4hz);
      mv = mode_view(st_reg.mode, port_in[i]);
      if (!port_in[i].link && !(st_reg.mode == PSL_MODE_D)
          && !(st_reg.mode == PSL_MODE_B && port_in[i].conn_problem
               && !port_in[i].autoneg)) begin
        st_next.lamps[i] = PSL_OFF;
      end else if (st_reg.mode == PSL_MODE_A) begin
        // activity only replaces the steady green of a forwarding port
        st_next.lamps[i] = (port_in[i].mirror_dest || port_in[i].admin_off
                            || port_in[i].blocking || mv == PSL_OFF) ? lv : mv;
      end else begin
        st_next.lamps[i] = mv;
      end
      if (port_in[i].monitored && !port_in[i].link) begin
        any_fault = 1'b1;
      end
    end
    st_next.fault = any_fault;

    // configuration plug handling
    st_next.pcmd = '0;
    st_next.pcmd.use_internal = (st_reg.plug == PSL_PLG_NONE);
    case (st_reg.plug)
      PSL_PLG_BOOT: begin
        if (!plug_in.present) begin
          st_next.plug = PSL_PLG_NONE;
        end else if (plug_in.malfunction) begin
          st_next.plug = PSL_PLG_FAULT;
        end else if (plug_in.empty) begin
          st_next.plug = PSL_PLG_SAVE;
        end else if (plug_in.compatible) begin
          st_next.plug = PSL_PLG_LOAD;
        end else begin
          st_next.plug = PSL_PLG_FAULT;
        end
      end
      PSL_PLG_SAVE: begin
        st_next.pcmd.save_all = 1'b1;
        if (plug_in.xfer_done) st_next.plug = PSL_PLG_RUN;
      end
      PSL_PLG_LOAD: begin
        st_next.pcmd.load_all = 1'b1;
        if (plug_in.xfer_done) st_next.plug = PSL_PLG_RUN;
      end
      PSL_PLG_RUN: begin
        st_next.pcmd.write_changes = cfg_change_in;
      end
      PSL_PLG_NONE: begin
        st_next.pcmd.use_internal = 1'b1;
      end
      PSL_PLG_FAULT: begin
      end
      default: st_next.plug = PSL_PLG_FAULT;
    endcase
    if ((st_reg.plug == PSL_PLG_SAVE || st_reg.plug == PSL_PLG_LOAD
         || st_reg.plug == PSL_PLG_RUN)
        && (!plug_in.present || plug_in.malfunction)) begin
      st_next.plug = PSL_PLG_FAULT;
      st_next.pcmd.save_all = 1'b0;
      st_next.pcmd.load_all = 1'b0;
      st_next.pcmd.write_changes = 1'b0;
    end
    st_next.diag = (st_next.plug == PSL_PLG_FAULT);
    st_next.pcmd.diag_fault = st_next.diag;
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end

  assign per_port_status_lamps_out = st_reg.lamps;
  assign display_mode_out = st_reg.mode;
  assign fault_contact_out = st_reg.fault | st_reg.diag;
  assign error_state_out = st_reg.fault;
  assign plug_out = st_reg.pcmd;
  assign plug_state_out = st_reg.plug;

  // mode lamp: A off, B green, C orange, D flashes yellow/orange
  always_comb begin
    case (st_reg.mode)
      PSL_MODE_B: display_mode_lamp_out = PSL_GREEN;
      PSL_MODE_C: display_mode_lamp_out = PSL_ORANGE;
      PSL_MODE_D: display_mode_lamp_out = fl_1hz ? PSL_YELLOW : PSL_ORANGE;
      default: display_mode_lamp_out = PSL_OFF;
    endcase
  end

endmodule : psl_port_lamps

// *** sim/psl_lamps_sva.sv ***
// port-level assertions for the port status lamp block
module psl_lamps_sva
  import psl_pkg::*;
#(
  parameter int unsigned NUM_PORTS = 8
) (
  input wire logic clock_in, // clock
  input wire logic rst_n_in, // reset, active low
  input wire logic ce_in, // clock enable
  input wire psl_port_t [NUM_PORTS-1:0] port_in, // port status
  input wire logic button_press_in, // mode press
  input wire logic cfg_change_in, // config change
  input wire psl_color_t [NUM_PORTS-1:0] per_port_status_lamps_out, // lamps
  input wire psl_mode_t display_mode_out, // mode
  input wire logic fault_contact_out, // contact
  input wire logic error_state_out, // error
  input wire psl_plug_out_t plug_out, // plug commands
  input wire psl_plug_state_t plug_state_out // plug state
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  psl_port_t p;
  psl_color_t l;
  assign p = port_in[0];
  assign l = per_port_status_lamps_out[0];
  nolink_dark_a: assert property ($past(!p.link && display_mode_out == PSL_MODE_A)
    && $stable(display_mode_out) |-> l == PSL_OFF) else $error("lamp lit without link");
  forward_green_a: assert property ($past(p.link && !p.blocking && !p.admin_off
    && !p.mirror_dest && !p.rx_act && !p.tx_act && display_mode_out == PSL_MODE_A)
    && $stable(display_mode_out) |-> l == PSL_GREEN) else $error("forwarding not green");
  speed_gig_a: assert property ($past(display_mode_out == PSL_MODE_B && p.link
    && !p.conn_problem && p.speed == PSL_SPD_1000) && $stable(display_mode_out)
    |-> l == PSL_ORANGE) else $error("gigabit not orange");
  duplex_view_a: assert property ($past(display_mode_out == PSL_MODE_C && p.link)
    && $stable(display_mode_out) |-> l == ($past(p.full_duplex) ? PSL_GREEN : PSL_OFF))
    else $error("duplex lamp wrong");
  monitor_view_a: assert property ($past(display_mode_out == PSL_MODE_D)
    && $stable(display_mode_out) |-> l == ($past(p.monitored) ? PSL_GREEN : PSL_OFF))
    else $error("monitor lamp wrong");
  link_fault_a: assert property (p.monitored && !p.link
    |=> fault_contact_out && error_state_out) else $error("link fault not raised");
  mode_step_a: assert property (button_press_in && ce_in
    |=> display_mode_out == $past(display_mode_out) + 2'h1) else $error("mode not advanced");
  cfg_write_a: assert property (cfg_change_in && plug_state_out == PSL_PLG_RUN
    |-> ##[1:2] plug_out.write_changes) else $error("change not written");
  plug_fault_a: assert property (plug_state_out == PSL_PLG_FAULT |=>
    plug_state_out == PSL_PLG_FAULT && plug_out.diag_fault && !plug_out.save_all)
    else $error("plug fault not held");
endmodule : psl_lamps_sva

// *** sim/testbench.sv ***
// self-checking bench for the port status lamp block
module testbench
  import psl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic ce_in = 1'b1;
  psl_port_t [1:0] port_in = '0;
  logic button_press_in = 1'b0;
  logic cfg_change_in = 1'b0;
  psl_plug_in_t plug_in = '0;
  psl_color_t [1:0] lamps;
  psl_mode_t mode;
  psl_color_t mlamp;
  logic fault;
  logic err;
  psl_plug_out_t plug_out;
  psl_plug_state_t pst;
  int n_mismatch = 0;
  int total_checks = 0;
  psl_port_t pt = '0;
  always #2 clock_in = ~clock_in;
  psl_port_lamps #(.NUM_PORTS(2), .TICK_CYC(4), .IDLE_TICKS(30)) psl_port_lamps_i (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .port_in(port_in),
    .button_press_in(button_press_in), .cfg_change_in(cfg_change_in), .plug_in(plug_in),
    .per_port_status_lamps_out(lamps), .display_mode_out(mode), .display_mode_lamp_out(mlamp),
    .fault_contact_out(fault), .error_state_out(err), .plug_out(plug_out),
    .plug_state_out(pst));
  task automatic step(int n);
    repeat (n) @(negedge clock_in);
  endtask : step
  task automatic chk(bit ok, string m);
    total_checks++;
    if (!ok) begin
      n_mismatch++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  task automatic rst(logic [4:0] pl);
    rst_n_in = 1'b0;
    plug_in = psl_plug_in_t'(pl);
    step(6);
    rst_n_in = 1'b1;
    step(2);
  endtask : rst
  // bounded wait for one plug command bit
  task automatic poll(int b, string m);
    int i;
    for (i = 0; i < 10 && plug_out[b] !== 1'b1; i++) step(1);
    chk(i < 10, m);
    if (i == 10) close_out();
  endtask : poll
  task automatic press();
    button_press_in = 1'b1;
    step(1);
    button_press_in = 1'b0;
    step(1);
  endtask : press
  // count green rises and green cycles over one second of 96 cycles
  task automatic fl(int n, int on);
    int r;
    int k;
    psl_color_t q;
    r = 0;
    k = 0;
    port_in = {pt, pt};
    step(2);
    q = lamps[0];
    repeat (96) begin
      step(1);
      if (lamps[0] === PSL_GREEN && q !== PSL_GREEN) r++;
      if (lamps[0] === PSL_GREEN) k++;
      chk(lamps[1] === lamps[0], "ports out of phase");
      q = lamps[0];
    end
    chk(r == n && k == on, "flash pattern");
  endtask : fl
  function automatic int spd(psl_speed_t s);
    return s == PSL_SPD_10 ? 0 : s == PSL_SPD_100 ? 1 : 3;
  endfunction : spd
  // expected lamp colour, -1 where the lamp flashes
  function automatic int model(psl_port_t p, int m);
    if (m == 1) return p.conn_problem ? (p.autoneg ? 0 : spd(p.set_speed)) : p.link ? spd(p.speed) : 0;
    if (m == 2) return p.link && p.full_duplex;
    if (m == 3) return p.monitored;
    if (!p.link) return 0;
    if (p.mirror_dest || p.admin_off || p.blocking) return -1;
    return p.rx_act || (p.optical_gig && p.tx_act) ? 2 : 1;
  endfunction : model
  task automatic rnd(int m);
    int e;
    repeat (12) begin
      pt = psl_port_t'(16'($urandom()));
      pt.speed = psl_speed_t'($urandom_range(2));
      pt.set_speed = psl_speed_t'($urandom_range(2));
      port_in = {pt, pt};
      step(2);
      e = model(pt, m);
      if (e >= 0) chk(lamps[0] === psl_color_t'(e), "lamp vs model");
    end
  endtask : rnd
  initial begin
    void'($urandom(10));
    rst(5'h00);
    poll(1, "internal memory not used");
    chk(plug_out.save_all === 1'b0 && plug_out.load_all === 1'b0, "plug cmd");
    pt.monitored = 1'b1;
    port_in = {pt, pt};
    step(2);
    chk(fault === 1'b1 && err === 1'b1, "monitored link loss");
    pt.monitored = 1'b0;
    port_in = {pt, pt};
    step(2);
    chk(fault === 1'b0 && err === 1'b0, "unmonitored link loss");
    pt.link = 1'b1;
    fl(0, 96);
    pt.rx_act = 1'b1;
    pt.blocking = 1'b1;
    fl(1, 48);
    pt.admin_off = 1'b1;
    fl(3, 48);
    pt.mirror_dest = 1'b1;
    fl(4, 48);
    pt.link = 1'b0;
    fl(0, 0);
    for (int m = 0; m < 4; m++) begin
      chk(mode === psl_mode_t'(m), "display mode");
      if (m < 3) chk(mlamp === psl_color_t'(m == 2 ? 3 : m), "mode lamp");
      else chk(mlamp === PSL_YELLOW || mlamp === PSL_ORANGE, "mode lamp");
      rnd(m);
      press();
    end
    chk(mode === PSL_MODE_A, "mode wrap");
    ce_in = 1'b0;
    press();
    chk(mode === PSL_MODE_A, "mode moved while frozen");
    ce_in = 1'b1;
    press();
    step(100);
    chk(mode === PSL_MODE_B, "early idle return");
    step(40);
    chk(mode === PSL_MODE_A, "idle return");
    port_in = '0;
    rst(5'h18);
    poll(4, "save to empty plug");
    chk(plug_out.use_internal === 1'b0, "internal memory used");
    plug_in.xfer_done = 1'b1;
    step(1);
    plug_in.xfer_done = 1'b0;
    step(2);
    chk(pst === PSL_PLG_RUN, "plug not running");
    cfg_change_in = 1'b1;
    step(1);
    cfg_change_in = 1'b0;
    poll(2, "change not written");
    plug_in.present = 1'b0;
    poll(0, "removal diagnostic");
    rst(5'h14);
    poll(3, "load accepted plug");
    rst(5'h10);
    poll(0, "incompatible plug");
    chk(plug_out.load_all === 1'b0, "incompatible loaded");
    rst(5'h16);
    poll(0, "plug malfunction");
    close_out();
  end
endmodule : testbench
bind psl_port_lamps psl_lamps_sva #(.NUM_PORTS(NUM_PORTS)) psl_lamps_sva_i (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .port_in(port_in),
  .button_press_in(button_press_in), .cfg_change_in(cfg_change_in),
  .per_port_status_lamps_out(per_port_status_lamps_out), .display_mode_out(display_mode_out),
  .fault_contact_out(fault_contact_out), .error_state_out(error_state_out),
  .plug_out(plug_out), .plug_state_out(plug_state_out));
